/* File: core/rpel_map.svh */
`ifndef RPEL_MAP_SVH
`define RPEL_MAP_SVH
// register byte offsets in configuration space
`define RPEL_OFF_CAPCTL 12'h160
`define RPEL_OFF_HDR0 12'h164
`define RPEL_OFF_HDR1 12'h168
`define RPEL_OFF_HDR2 12'h16c
`define RPEL_OFF_HDR3 12'h170
`define RPEL_OFF_CMD 12'h174
`define RPEL_OFF_STS 12'h178
`define RPEL_OFF_SRC 12'h17c
// capability/control fields
`define RPEL_CAP_CHK_EN 8
`define RPEL_CAP_CHK_CAP 7
`define RPEL_CAP_GEN_EN 6
`define RPEL_CAP_GEN_CAP 5
`define RPEL_CAP_CHK_CAP_RST 1'b1
`define RPEL_CAP_GEN_CAP_RST 1'b1
// command fields
`define RPEL_CMD_FAT 2
`define RPEL_CMD_NF 1
`define RPEL_CMD_COR 0
// status fields
`define RPEL_STS_COR 0
`define RPEL_STS_MCOR 1
`define RPEL_STS_UNC 2
`define RPEL_STS_MUNC 3
`define RPEL_STS_FFAT 4
`define RPEL_STS_NFSEEN 5
`define RPEL_STS_FSEEN 6
`define RPEL_STS_NUM_HI 31
`define RPEL_STS_NUM_LO 27
`define RPEL_MSGNUM_TWO 5'h01
`define RPEL_VEC_TWO 6'h02
`endif

/* File: core/rpel_pkg.sv */
package rpel_pkg;
  // category of an error message arriving at the port
  typedef enum logic [1:0] {
    RPEL_MSG_COR = 2'h0,
    RPEL_MSG_NF = 2'h1,
    RPEL_MSG_FAT = 2'h3
  } rpel_msg_type;
  // first-error pointer arm state
  typedef enum logic {
    RPEL_ARMED = 1'b0,
    RPEL_FROZEN = 1'b1
  } rpel_fep_type;
endpackage

/* File: core/rpel_root_port_error_logging.sv */
`timescale 1ns/1ps
`include "rpel_map.svh"
// Function
// - five-bit pointer to first unmasked error
// - same-cycle fatal beats non-fatal as first
// - pointer frozen until pointed bit cleared
// - first error header kept in four words
// - sticky check enable, check capable resets one
// - sticky generate enable, generate capable resets one
// - fatal interrupt only when fatal enable set
// - nonfatal and correctable interrupts need enables
// - first correctable message sets received flag
// - later correctable sets multiple flag
// - first uncorrectable sets received flag
// - later uncorrectable sets multiple flag
// - first uncorrectable fatal sets first-fatal flag
// - fatal and nonfatal seen flags set always
// - write one clears status, zero ignored
// - fatal and nonfatal share uncorrectable category
// - message number reads one with two vectors
// - uncorrectable source id logged when first
// - correctable source id logged when first
// - later message sets next, id discarded
// - own errors logged as own bus, device zero
module rpel_root_port_error_logging
  import rpel_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic pwr_rst_in,
  input wire logic clk_en_in,
  input wire logic [11:0] cfg_addr_in,
  input wire logic cfg_wr_in,
  input wire logic [31:0] cfg_wdata_in,
  input wire logic [3:0] cfg_be_in,
  input wire logic cfg_rd_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_ack_out,
  input wire logic msg_valid_in,
  input wire rpel_msg_type msg_kind_in,
  input wire logic [15:0] msg_req_id_in,
  input wire logic self_valid_in,
  input wire rpel_msg_type self_kind_in,
  input wire logic [7:0] socket_bus_number_in,
  input wire logic [31:0] unc_status_in,
  input wire logic [31:0] unc_mask_in,
  input wire logic [31:0] unc_sev_in,
  input wire logic [127:0] err_hdr_in,
  input wire logic [5:0] msi_vec_count_in,
  output logic ecrc_check_en_out,
  output logic ecrc_gen_en_out,
  output logic irq_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic chk_en_ff;
  logic gen_en_ff;
  logic chk_cap_ff;
  logic gen_cap_ff;
  logic [4:0] fep_ff;
  rpel_fep_type fep_st_ff;
  logic [31:0] hdr_ff [0:3];
  logic [2:0] cmd_ff;
  logic [6:0] sts_ff;
  logic [4:0] msgnum_ff;
  logic [15:0] src_unc_ff;
  logic [15:0] src_cor_ff;
  logic [31:0] unc_prev_ff;

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  logic wr_cap;
  logic wr_cmd;
  logic wr_sts;
  assign wr_cap = clk_en_in && cfg_wr_in && cfg_addr_in == `RPEL_OFF_CAPCTL && cfg_be_in[1];
  assign wr_cmd = clk_en_in && cfg_wr_in && cfg_addr_in == `RPEL_OFF_CMD && cfg_be_in[0];
  assign wr_sts = clk_en_in && cfg_wr_in && cfg_addr_in == `RPEL_OFF_STS && cfg_be_in[0];

  // ---------------------------------------------------------------
  // message merge
  // ---------------------------------------------------------------
  // own-detected errors look like a message from our own bus, device 0; a received
  // message wins the cycle, so the port's own event must be presented again by the core
  logic ev_any;
  rpel_msg_type ev_kind;
  logic [15:0] ev_id;
  logic ev_cor;
  logic ev_unc;
  logic ev_fat;
  assign ev_any = clk_en_in && (msg_valid_in || self_valid_in);
  assign ev_kind = msg_valid_in ? msg_kind_in : self_kind_in;
  assign ev_id = msg_valid_in ? msg_req_id_in : {socket_bus_number_in, 8'h00};
  assign ev_cor = ev_any && ev_kind == RPEL_MSG_COR;
  assign ev_unc = ev_any && ev_kind != RPEL_MSG_COR;
  assign ev_fat = ev_any && ev_kind == RPEL_MSG_FAT;

  // ---------------------------------------------------------------
  // capability and control
  // ---------------------------------------------------------------
  // enables are sticky: only power-on reset clears them
  always_ff @(posedge ref_clk_in or posedge pwr_rst_in) begin
    if (pwr_rst_in) begin
      chk_en_ff <= 1'b0;
      gen_en_ff <= 1'b0;
    end else if (wr_cap) begin
      chk_en_ff <= cfg_wdata_in[`RPEL_CAP_CHK_EN];
      gen_en_ff <= cfg_wdata_in[`RPEL_CAP_GEN_EN];
    end
  end

  // capability flags are read-only fields, left at their reset value
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      chk_cap_ff <= `RPEL_CAP_CHK_CAP_RST;
      gen_cap_ff <= `RPEL_CAP_GEN_CAP_RST;
      cmd_ff <= 3'h0;
    end else if (wr_cmd) begin
      cmd_ff <= cfg_wdata_in[2:0];
    end
  end

  // ---------------------------------------------------------------
  // first error pointer and header log
  // ---------------------------------------------------------------
  logic [31:0] unc_new;
  logic [31:0] unc_fat;
  logic [31:0] unc_pick;
  logic [4:0] pick_idx;
  logic pick_hit;
  assign unc_new = unc_status_in & ~unc_prev_ff & ~unc_mask_in;
  assign unc_fat = unc_new & unc_sev_in;
  assign unc_pick = (unc_fat != 32'h0) ? unc_fat : unc_new;

  // lowest new bit among the chosen severity class
  always_comb begin
    pick_idx = 5'h00;
    pick_hit = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (unc_pick[i]) begin
        pick_idx = 5'(i);
        pick_hit = 1'b1;
      end
    end
  end

  // edge detect on status bits from the same clock domain
  always_ff @(posedge ref_clk_in or posedge pwr_rst_in) begin
    if (pwr_rst_in) begin
      unc_prev_ff <= 32'h0;
    end else if (clk_en_in) begin
      unc_prev_ff <= unc_status_in;
    end
  end

  // pointer and header freeze together; rearm when the pointed status bit drops
  always_ff @(posedge ref_clk_in or posedge pwr_rst_in) begin
    if (pwr_rst_in) begin
      fep_ff <= 5'h00;
      fep_st_ff <= RPEL_ARMED;
      for (int i = 0; i < 4; i++) begin
        hdr_ff[i] <= 32'h0;
      end
    end else if (clk_en_in) begin
      unique case (fep_st_ff)
        RPEL_ARMED: begin
          if (pick_hit) begin
            fep_ff <= pick_idx;
            fep_st_ff <= RPEL_FROZEN;
            for (int i = 0; i < 4; i++) begin
              hdr_ff[i] <= err_hdr_in[32*i +: 32];
            end
          end
        end
        RPEL_FROZEN: begin
          if (!unc_status_in[fep_ff]) begin
            fep_st_ff <= RPEL_ARMED;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // root error status and source id
  // ---------------------------------------------------------------
  logic [6:0] clr;
  logic [6:0] set;
  assign clr = wr_sts ? cfg_wdata_in[6:0] : 7'h00;
  always_comb begin
    set = 7'h00;
    set[`RPEL_STS_COR] = ev_cor && !sts_ff[`RPEL_STS_COR];
    set[`RPEL_STS_MCOR] = ev_cor && sts_ff[`RPEL_STS_COR];
    set[`RPEL_STS_UNC] = ev_unc && !sts_ff[`RPEL_STS_UNC];
    set[`RPEL_STS_MUNC] = ev_unc && sts_ff[`RPEL_STS_UNC];
    set[`RPEL_STS_FFAT] = ev_fat && !sts_ff[`RPEL_STS_UNC];
    set[`RPEL_STS_NFSEEN] = ev_unc && !ev_fat;
    set[`RPEL_STS_FSEEN] = ev_fat;
  end

  // a set in the same cycle as a clear wins so no event is lost
  always_ff @(posedge ref_clk_in or posedge pwr_rst_in) begin
    if (pwr_rst_in) begin
      sts_ff <= 7'h00;
    end else if (clk_en_in) begin
      sts_ff <= (sts_ff & ~clr) | set;
    end
  end

  // id logged only by the message that raises the first flag; later ones dropped
  always_ff @(posedge ref_clk_in or posedge pwr_rst_in) begin
    if (pwr_rst_in) begin
      src_unc_ff <= 16'h0000;
      src_cor_ff <= 16'h0000;
    end else begin
      if (set[`RPEL_STS_UNC]) begin
        src_unc_ff <= ev_id;
      end
      if (set[`RPEL_STS_COR]) begin
        src_cor_ff <= ev_id;
      end
    end
  end

  // message number offset follows the vector allocation
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      msgnum_ff <= 5'h00;
    end else if (clk_en_in) begin
      msgnum_ff <= (msi_vec_count_in == `RPEL_VEC_TWO) ? `RPEL_MSGNUM_TWO : 5'h00;
    end
  end

  // ---------------------------------------------------------------
  // interrupt request
  // ---------------------------------------------------------------
  // one-cycle pulse per newly set first flag; msi or intx selection is outside
  logic irq_req;
  assign irq_req = (set[`RPEL_STS_COR] && cmd_ff[`RPEL_CMD_COR])
    || (set[`RPEL_STS_UNC] && ev_fat && cmd_ff[`RPEL_CMD_FAT])
    || (set[`RPEL_STS_UNC] && !ev_fat && cmd_ff[`RPEL_CMD_NF]);
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'b0;
      ecrc_check_en_out <= 1'b0;
      ecrc_gen_en_out <= 1'b0;
    end else if (clk_en_in) begin
      irq_out <= irq_req;
      ecrc_check_en_out <= chk_en_ff;
      ecrc_gen_en_out <= gen_en_ff;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    unique case (cfg_addr_in)
      `RPEL_OFF_CAPCTL: rd_mux = {23'h0, chk_en_ff, chk_cap_ff, gen_en_ff, gen_cap_ff, fep_ff};
      `RPEL_OFF_HDR0: rd_mux = hdr_ff[0];
      `RPEL_OFF_HDR1: rd_mux = hdr_ff[1];
      `RPEL_OFF_HDR2: rd_mux = hdr_ff[2];
      `RPEL_OFF_HDR3: rd_mux = hdr_ff[3];
      `RPEL_OFF_CMD: rd_mux = {29'h0, cmd_ff};
      `RPEL_OFF_STS: rd_mux = {msgnum_ff, 20'h0, sts_ff};
      `RPEL_OFF_SRC: rd_mux = {src_unc_ff, src_cor_ff};
      default: rd_mux = 32'h0;
    endcase
  end

  // reads answer one cycle later, unmapped offsets read zero
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_rdata_out <= 32'h0;
      cfg_ack_out <= 1'b0;
    end else if (clk_en_in) begin
      cfg_ack_out <= cfg_rd_in || cfg_wr_in;
      cfg_rdata_out <= cfg_rd_in ? rd_mux : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_cor_first;
    @(posedge ref_clk_in) disable iff (pwr_rst_in)
    ev_cor && !sts_ff[`RPEL_STS_COR] |=> sts_ff[`RPEL_STS_COR] && src_cor_ff == $past(ev_id);
  endproperty
  a_cor_first: assert property (p_cor_first) else $error("correctable first not logged");

  property p_cor_next;
    @(posedge ref_clk_in) disable iff (pwr_rst_in)
    ev_cor && sts_ff[`RPEL_STS_COR] |=> sts_ff[`RPEL_STS_MCOR] && $stable(src_cor_ff);
  endproperty
  a_cor_next: assert property (p_cor_next) else $error("next correctable wrong");

  property p_unc_first;
    @(posedge ref_clk_in) disable iff (pwr_rst_in)
    ev_unc && !sts_ff[`RPEL_STS_UNC] |=> sts_ff[`RPEL_STS_UNC] && src_unc_ff == $past(ev_id);
  endproperty
  a_unc_first: assert property (p_unc_first) else $error("uncorrectable first not logged");

  property p_unc_next;
    @(posedge ref_clk_in) disable iff (pwr_rst_in)
    ev_unc && sts_ff[`RPEL_STS_UNC] |=> sts_ff[`RPEL_STS_MUNC] && $stable(src_unc_ff);
  endproperty
  a_unc_next: assert property (p_unc_next) else $error("next uncorrectable wrong");

  property p_first_fatal;
    @(posedge ref_clk_in) disable iff (pwr_rst_in)
    ev_fat && !sts_ff[`RPEL_STS_UNC] |=> sts_ff[`RPEL_STS_FFAT] && sts_ff[`RPEL_STS_FSEEN];
  endproperty
  a_first_fatal: assert property (p_first_fatal) else $error("first fatal not flagged");

  property p_w1c;
    @(posedge ref_clk_in) disable iff (pwr_rst_in)
    wr_sts && cfg_wdata_in[`RPEL_STS_MCOR] && !ev_any |=> !sts_ff[`RPEL_STS_MCOR];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_fep_hold;
    @(posedge ref_clk_in) disable iff (pwr_rst_in)
    fep_st_ff == RPEL_FROZEN && unc_status_in[fep_ff] |=> $stable(fep_ff) && $stable(hdr_ff[0]);
  endproperty
  a_fep_hold: assert property (p_fep_hold) else $error("first error log moved");

  // a frozen cycle holds the pulse, so only look where the previous edge advanced
  property p_irq_fat;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    irq_out && $past(clk_en_in) && $past(ev_fat) |-> $past(cmd_ff[`RPEL_CMD_FAT]);
  endproperty
  a_irq_fat: assert property (p_irq_fat) else $error("interrupt without enable");

  property p_self_id;
    @(posedge ref_clk_in) disable iff (pwr_rst_in)
    self_valid_in && !msg_valid_in && clk_en_in && self_kind_in == RPEL_MSG_COR
      && !sts_ff[`RPEL_STS_COR] |=> src_cor_ff == {$past(socket_bus_number_in), 8'h00};
  endproperty
  a_self_id: assert property (p_self_id) else $error("own source id wrong");

endmodule

/* File: testbench/rpel_msg_source.sv */
`timescale 1ns/1ps
// ----------------------------------------
// downstream device sending error messages
// ----------------------------------------
module rpel_msg_source
  import rpel_pkg::*;
(
  input wire logic clk_in,
  output logic valid_out,
  output rpel_msg_type kind_out,
  output logic [15:0] id_out
);
  // idle bus at time zero
  initial begin
    valid_out = 1'b0;
    kind_out = RPEL_MSG_COR;
    id_out = 16'h0000;
  end
  // one message per call, held for one sampling edge only
  task automatic send(input rpel_msg_type kind, input logic [15:0] id);
    @(posedge clk_in);
    valid_out <= 1'b1;
    kind_out <= kind;
    id_out <= id;
    @(posedge clk_in);
    valid_out <= 1'b0;
    id_out <= ~id; // stale id is inverted so it never passes for a fresh one
  endtask
endmodule

/* File: testbench/rpel_root_port_error_logging_tb_top.sv */
`timescale 1ns/1ps
`include "rpel_map.svh"
// ----------------------------------------
// error logging bench
// ----------------------------------------
module rpel_root_port_error_logging_tb_top;
  import rpel_pkg::*;
  logic ref_clk, sys_rst, pwr_rst, cfg_wr, cfg_rd, cfg_ack, msg_valid, self_valid;
  logic chk_en, gen_en, irq, clk_en;
  logic [11:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, unc_status, unc_mask, unc_sev;
  logic [3:0] cfg_be;
  rpel_msg_type msg_kind, self_kind;
  logic [15:0] msg_id, id_a, id_b;
  logic [7:0] bus;
  logic [127:0] hdr, h1, h2;
  logic [5:0] vec_count;
  int n_mismatch, n_checks, k;

  rpel_msg_source rpel_msg_source_inst (.clk_in(ref_clk), .valid_out(msg_valid),
    .kind_out(msg_kind), .id_out(msg_id));
  rpel_root_port_error_logging rpel_root_port_error_logging_inst (
    .ref_clk_in(ref_clk), .sys_rst_in(sys_rst), .pwr_rst_in(pwr_rst), .clk_en_in(clk_en),
    .cfg_addr_in(cfg_addr), .cfg_wr_in(cfg_wr), .cfg_wdata_in(cfg_wdata),
    .cfg_be_in(cfg_be), .cfg_rd_in(cfg_rd), .cfg_rdata_out(cfg_rdata),
    .cfg_ack_out(cfg_ack), .msg_valid_in(msg_valid), .msg_kind_in(msg_kind),
    .msg_req_id_in(msg_id), .self_valid_in(self_valid), .self_kind_in(self_kind),
    .socket_bus_number_in(bus), .unc_status_in(unc_status), .unc_mask_in(unc_mask),
    .unc_sev_in(unc_sev), .err_hdr_in(hdr), .msi_vec_count_in(vec_count),
    .ecrc_check_en_out(chk_en), .ecrc_gen_en_out(gen_en), .irq_out(irq));

  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
  endtask
  // read and compare; ack and data stand for the one cycle after the request
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge ref_clk);
    cfg_rd <= 1'b0;
    #1;
    chk({31'h0, cfg_ack}, 32'h1);
    chk(cfg_rdata, exp);
  endtask
  // count irq-high cycles over a short window, so a stretched pulse fails too
  task automatic watch_irq(input int exp);
    int seen;
    seen = 0;
    // the pulse already stands when a send returns, so look before each edge
    repeat (4) begin
      #1;
      if (irq === 1'b1) seen++;
      @(posedge ref_clk);
    end
    chk(32'(seen), 32'(exp));
  endtask
  task automatic self_err(input rpel_msg_type kind);
    @(posedge ref_clk);
    self_valid <= 1'b1;
    self_kind <= kind;
    @(posedge ref_clk);
    self_valid <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard, far beyond the fewer than two hundred cycles the tests need
  initial begin
    #20000;
    n_mismatch++;
    tally_and_finish();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    n_mismatch = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    pwr_rst = 1'b1;
    {cfg_wr, cfg_rd, self_valid} = 3'h0;
    cfg_addr = 12'h000;
    cfg_wdata = 32'h0;
    cfg_be = 4'hf;
    clk_en = 1'b1;
    self_kind = RPEL_MSG_COR;
    {unc_status, unc_mask, unc_sev} = {3{32'h0}};
    vec_count = 6'h01;
    void'($urandom(40));
    bus = 8'($urandom);
    id_a = 16'($urandom);
    id_b = 16'($urandom);
    h1 = {$urandom, $urandom, $urandom, $urandom};
    h2 = ~h1;
    hdr = 128'h0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    pwr_rst <= 1'b0;
    rd(`RPEL_OFF_CAPCTL, 32'h000000a0);
    for (k = 1; k < 8; k++) rd(12'h160 + 12'(4 * k), 32'h0);
    rd(12'h180, 32'h0);
    wr(`RPEL_OFF_HDR0, 32'hffffffff);
    rd(`RPEL_OFF_HDR0, 32'h0);
    // correctable first then next, interrupts still disabled
    rpel_msg_source_inst.send(RPEL_MSG_COR, id_a);
    watch_irq(0);
    rd(`RPEL_OFF_STS, 32'h1);
    rd(`RPEL_OFF_SRC, {16'h0, id_a});
    rpel_msg_source_inst.send(RPEL_MSG_COR, id_b);
    rd(`RPEL_OFF_STS, 32'h3);
    rd(`RPEL_OFF_SRC, {16'h0, id_a});
    wr(`RPEL_OFF_STS, 32'h0);
    rd(`RPEL_OFF_STS, 32'h3);
    wr(`RPEL_OFF_STS, 32'h1);
    rd(`RPEL_OFF_STS, 32'h2);
    wr(`RPEL_OFF_CMD, 32'h7);
    rd(`RPEL_OFF_CMD, 32'h7);
    // fatal then non-fatal share one category
    rpel_msg_source_inst.send(RPEL_MSG_FAT, id_b);
    watch_irq(1);
    rd(`RPEL_OFF_STS, 32'h56);
    rd(`RPEL_OFF_SRC, {id_b, id_a});
    rpel_msg_source_inst.send(RPEL_MSG_NF, id_a);
    watch_irq(0);
    rd(`RPEL_OFF_STS, 32'h7e);
    rd(`RPEL_OFF_SRC, {id_b, id_a});
    wr(`RPEL_OFF_STS, 32'h7f);
    rd(`RPEL_OFF_STS, 32'h0);
    // port's own non-fatal error
    self_err(RPEL_MSG_NF);
    watch_irq(1);
    rd(`RPEL_OFF_STS, 32'h24);
    rd(`RPEL_OFF_SRC, {bus, 8'h00, id_a});
    // only correctable interrupts enabled now
    wr(`RPEL_OFF_STS, 32'h7f);
    wr(`RPEL_OFF_CMD, 32'h1);
    rpel_msg_source_inst.send(RPEL_MSG_FAT, id_a);
    watch_irq(0);
    rpel_msg_source_inst.send(RPEL_MSG_COR, id_b);
    watch_irq(1);
    @(posedge ref_clk);
    vec_count <= 6'h02;
    repeat (2) @(posedge ref_clk);
    rd(`RPEL_OFF_STS, 32'h08000055);
    // enables, then an ordinary reset that must spare sticky state
    wr(`RPEL_OFF_CAPCTL, 32'hffffffff);
    rd(`RPEL_OFF_CAPCTL, 32'h000001e0);
    chk({31'h0, chk_en}, 32'h1);
    chk({31'h0, gen_en}, 32'h1);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(`RPEL_OFF_CAPCTL, 32'h000001e0);
    rd(`RPEL_OFF_CMD, 32'h0);
    rd(`RPEL_OFF_SRC, {id_a, id_b});
    // same-cycle fatal bit 20 and non-fatal bit 12
    @(posedge ref_clk);
    unc_sev <= 32'h00100000;
    unc_status <= 32'h00101000;
    hdr <= h1;
    repeat (3) @(posedge ref_clk);
    rd(`RPEL_OFF_CAPCTL, 32'h000001f4);
    for (k = 0; k < 4; k++) rd(`RPEL_OFF_HDR0 + 12'(4 * k), h1[32 * k +: 32]);
    @(posedge ref_clk);
    hdr <= h2;
    unc_status <= 32'h00109000;
    repeat (3) @(posedge ref_clk);
    rd(`RPEL_OFF_CAPCTL, 32'h000001f4);
    rd(`RPEL_OFF_HDR0, h1[31:0]);
    // clearing the pointed bit rearms capture
    @(posedge ref_clk);
    unc_status <= 32'h0;
    repeat (3) @(posedge ref_clk);
    unc_status <= 32'h00004000;
    repeat (3) @(posedge ref_clk);
    rd(`RPEL_OFF_CAPCTL, 32'h000001ee);
    rd(`RPEL_OFF_HDR3, h2[127:96]);
    // a message while the clock enable is low must leave no trace
    wr(`RPEL_OFF_STS, 32'h7f);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    rpel_msg_source_inst.send(RPEL_MSG_COR, id_a);
    clk_en <= 1'b1;
    rd(`RPEL_OFF_STS, 32'h08000000);
    rd(`RPEL_OFF_SRC, {id_a, id_b});
    tally_and_finish();
  end
endmodule
